// >>> spi_port_pkg.sv
// Shared constants and carrier types for the sensor serial slave port.
package spi_port_pkg;

  localparam int          BYTE_BITS      = 8;
  localparam int          ADDR_BITS      = 7;
  localparam int          DIR_BIT        = 7;
  localparam logic        DIR_WRITE      = 1'b1;
  localparam logic [6:0]  PORT_MODE_ADDR = 7'h1c;
  localparam logic [7:0]  BURST_ENABLE   = 8'h10;
  localparam logic [6:0]  MOTION_ADDR    = 7'h02;
  localparam int          BURST_LEN      = 7;
  localparam logic [2:0]  BURST_LAST     = 3'h6;
  localparam int          NUM_REGS       = 128;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

  // Serial pins after two-flop synchronisation.
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_low;
  } spi_pins_s;

  // One completed register write seen by the register store.
  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_write_s;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_WDATA = 5'b00100,
    ST_RDATA = 5'b01000,
    ST_LOCK  = 5'b10000
  } port_state_e;

endpackage : spi_port_pkg

// >>> spi_reg_store.sv
// Register store addressed by index, written and read by the serial port.
`timescale 1ns/10ps
`default_nettype none

module spi_reg_store
  import spi_port_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire spi_port_pkg::reg_write_s wr,
  input  wire logic [6:0]         rd_addr,
  output logic [7:0]              rd_data
);

  logic [7:0] regs      [NUM_REGS];
  logic [7:0] next_regs [NUM_REGS];

  always_comb
  begin
    next_regs = regs;
    if (wr.valid)
    begin
      next_regs[wr.addr] = wr.data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        regs[i] <= REG_RESET;
      end
    end
    else
    begin
      regs <= next_regs;
    end
  end

  assign rd_data = regs[rd_addr];

endmodule // spi_reg_store

`default_nettype wire

// >>> sensor_spi_slave_port.sv
// Four-wire serial slave port of the sensor: command decode, read-back and burst.
// What this block does
// - Slave only; host starts every transfer.
// - Deselected: ignore inputs, data output floats.
// - Chip select rising aborts, port returns idle.
// - Burst ends only by raising chip select.
// - Write: direction 1, seven-bit address, data.
// - Read: direction 0 address, device returns data.
// - Sample on rising edge, shift on falling.
// - Write 0x10 to 0x1c arms burst mode.
// - Burst streams seven values, may stop after three.
`timescale 1ns/10ps
`default_nettype none

module sensor_spi_slave_port
  import spi_port_pkg::*;
(
  input  wire logic MCLK,
  input  wire logic RESET_N,
  input  wire logic SCLK,
  input  wire logic MOSI,
  input  wire logic CHIP_SELECT_LOW,
  output logic      MISO_OUT,
  output logic      MISO_OE,
  output logic      BURST_ARMED
);
  import spi_port_pkg::*;

  // Every pin passes two flops; only the second stage is read by logic.
  spi_pins_s   sync1;
  spi_pins_s   sync2;
  logic        sclk_prev;
  logic        cs_prev;

  port_state_e state;
  port_state_e next_state;
  logic [2:0]  bit_cnt;
  logic [2:0]  next_bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  next_shift_in;
  logic [7:0]  shift_out;
  logic [7:0]  next_shift_out;
  logic [6:0]  addr;
  logic [6:0]  next_addr;
  logic [2:0]  burst_idx;
  logic [2:0]  next_burst_idx;
  logic        burst_mode;
  logic        next_burst_mode;
  logic        miso;
  logic        next_miso;
  logic        miso_oe;
  logic        next_miso_oe;
  reg_write_s  wr;
  reg_write_s  next_wr;
  logic [6:0]  rd_addr;
  logic [7:0]  rd_data;

  logic        selected;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;
  logic [7:0]  byte_in;

  spi_reg_store u_store (
    .clk     (MCLK),
    .reset_n (RESET_N),
    .wr      (wr),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  assign selected  = !sync2.cs_low;
  assign sclk_rise = selected && sync2.sclk && !sclk_prev;
  assign sclk_fall = selected && !sync2.sclk && sclk_prev;
  assign cs_rise   = !selected && cs_prev;
  assign byte_in   = {shift_in[6:0], sync2.mosi};

  // The burst walks the motion block at consecutive addresses from the motion register,
  // so outside address decode the store is always looking one address ahead.
  assign rd_addr   = (state == ST_ADDR) ? byte_in[6:0] : addr + 7'h01;

  always_comb
  begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shift_in   = shift_in;
    next_shift_out  = shift_out;
    next_addr       = addr;
    next_burst_idx  = burst_idx;
    next_burst_mode = burst_mode;
    next_miso       = miso;
    next_miso_oe    = miso_oe;
    next_wr         = '0;
    if (!selected)
    begin
      // Deselect aborts anything in flight; it closes burst mode only if it comes in ST_LOCK.
      next_state   = ST_IDLE;
      next_bit_cnt = '0;
      next_miso_oe = 1'b0;
      if (cs_rise && state == ST_LOCK)
      begin
        next_burst_mode = 1'b0;
      end
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // Nothing is driven until the host has selected the port.
          next_state   = ST_ADDR;
          next_bit_cnt = '0;
        end
        ST_ADDR:
        begin
          if (sclk_rise)
          begin
            next_shift_in = byte_in;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST)
            begin
              next_addr = byte_in[6:0];
              if (byte_in[DIR_BIT] == DIR_WRITE)
              begin
                next_state = ST_WDATA;
              end
              else
              begin
                // Read data is latched right after the last address bit.
                next_state     = ST_RDATA;
                next_shift_out = rd_data;
                next_burst_idx = '0;
              end
            end
          end
        end
        ST_WDATA:
        begin
          if (sclk_rise)
          begin
            next_shift_in = byte_in;
            next_bit_cnt  = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST)
            begin
              next_wr = '{valid: 1'b1, addr: addr, data: byte_in};
              if (addr == PORT_MODE_ADDR && byte_in == BURST_ENABLE)
              begin
                next_burst_mode = 1'b1;
              end
              next_state = ST_ADDR;
            end
          end
        end
        ST_RDATA:
        begin
          if (sclk_fall)
          begin
            // Each bit stands from one falling edge to the next.
            next_miso      = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
            next_miso_oe   = 1'b1;
          end
          else if (sclk_rise)
          begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == BIT_LAST)
            begin
              if (burst_mode && addr == MOTION_ADDR + {4'h0, burst_idx})
              begin
                if (burst_idx == BURST_LAST)
                begin
                  next_state = ST_LOCK;
                end
                else
                begin
                  next_burst_idx = burst_idx + 3'h1;
                  next_addr      = addr + 7'h01;
                  next_shift_out = rd_data;
                  next_state     = ST_RDATA;
                end
              end
              else
              begin
                next_state = ST_ADDR;
              end
            end
          end
        end
        ST_LOCK:
        begin
          // Clocks are ignored until chip select rises.
          next_state = ST_LOCK;
        end
        default:
        begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RESET_N)
    begin
      // Reset mirrors the idle pins so that no false clock edge follows release.
      sync1      <= '{sclk: 1'b1, mosi: 1'b0, cs_low: 1'b1};
      sync2      <= '{sclk: 1'b1, mosi: 1'b0, cs_low: 1'b1};
      sclk_prev  <= 1'b1;
      cs_prev    <= 1'b0;
      state      <= ST_IDLE;
      bit_cnt    <= '0;
      shift_in   <= '0;
      shift_out  <= '0;
      addr       <= '0;
      burst_idx  <= '0;
      burst_mode <= 1'b0;
      miso       <= 1'b0;
      miso_oe    <= 1'b0;
      wr         <= '0;
    end
    else
    begin
      sync1      <= '{sclk: SCLK, mosi: MOSI, cs_low: CHIP_SELECT_LOW};
      sync2      <= sync1;
      sclk_prev  <= sync2.sclk;
      cs_prev    <= selected;
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shift_in   <= next_shift_in;
      shift_out  <= next_shift_out;
      addr       <= next_addr;
      burst_idx  <= next_burst_idx;
      burst_mode <= next_burst_mode;
      miso       <= next_miso;
      miso_oe    <= next_miso_oe;
      wr         <= next_wr;
    end
  end

  assign MISO_OUT    = miso;
  assign MISO_OE     = miso_oe;
  assign BURST_ARMED = burst_mode;

endmodule // sensor_spi_slave_port

`default_nettype wire

// >>> spi_port_sva.sv
// Pin-level checks for the sensor serial slave port.
`timescale 1ns/10ps
`default_nettype none
module spi_port_sva (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic SCLK,
  input wire logic MOSI,
  input wire logic CHIP_SELECT_LOW,
  input wire logic MISO_OUT,
  input wire logic MISO_OE,
  input wire logic BURST_ARMED
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);
  desel_quiet_a: assert property (CHIP_SELECT_LOW [*5] |-> !MISO_OE)
    else $error("data out driven while deselected");
  abort_release_a: assert property ($rose(CHIP_SELECT_LOW) |-> ##[1:5] !MISO_OE)
    else $error("data out kept after abort");
  oe_start_a: assert property ($rose(MISO_OE) |-> !CHIP_SELECT_LOW && !$past(SCLK, 2))
    else $error("data out enabled off a falling clock");
  oe_hold_a: assert property (MISO_OE && !CHIP_SELECT_LOW |=> MISO_OE)
    else $error("data out dropped while selected");
  shift_fall_a: assert property (MISO_OE && $changed(MISO_OUT) |-> !$past(SCLK, 2))
    else $error("data out changed off a falling clock");
  arm_rise_a: assert property ($rose(BURST_ARMED) |-> !CHIP_SELECT_LOW && SCLK)
    else $error("burst armed outside a write");
  arm_stay_a: assert property (BURST_ARMED && !CHIP_SELECT_LOW |=> BURST_ARMED)
    else $error("burst left while selected");
  arm_exit_a: assert property ($fell(BURST_ARMED) |-> $past(CHIP_SELECT_LOW, 2))
    else $error("burst left without deselect");
endmodule // spi_port_sva
bind sensor_spi_slave_port spi_port_sva chk (.MCLK(MCLK), .RESET_N(RESET_N), .SCLK(SCLK),
  .MOSI(MOSI), .CHIP_SELECT_LOW(CHIP_SELECT_LOW), .MISO_OUT(MISO_OUT), .MISO_OE(MISO_OE),
  .BURST_ARMED(BURST_ARMED));
`default_nettype wire

// >>> spi_host_model.sv
// Behavioural host that masters the serial port.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input  wire logic mclk,
  input  wire logic miso,
  output logic      sclk,
  output logic      mosi,
  output logic      cs_low
);
  initial
  begin
    sclk = 1'b1;
    mosi = 1'b0;
    cs_low = 1'b1;
  end
  // Data is taken just before the next fall, since the device holds each bit fall to fall.
  task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      #200;
      sclk = 1'b1;
      #195;
      rx[i] = miso;
      #5;
    end
    mosi = ~mosi;
  endtask
  task automatic open_frame;
    @(negedge mclk);
    cs_low = 1'b0;
    #150;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    open_frame;
    shift({1'b1, a}, 8, r);
    shift(d, 8, r);
    #20000;
    cs_low = 1'b1;
    #30000;
  endtask
  task automatic rd(input logic [6:0] a, input int n, input bit lock, output logic [7:0] q [7]);
    logic [7:0] r;
    open_frame;
    shift({1'b0, a}, 8, r);
    #4000;
    for (int k = 0; k < n; k++)
      shift(8'h00, 8, q[k]);
    if (lock)
    begin
      shift({1'b1, 7'h05}, 8, r);
      shift(8'hee, 8, r);
    end
    #150;
    cs_low = 1'b1;
    #600;
  endtask
  // With sel low the bits go out deselected, as line noise would.
  task automatic cut(input logic [7:0] v, input int nb, input bit sel);
    logic [7:0] r;
    if (sel)
      open_frame;
    else
      @(negedge mclk);
    shift(v, nb, r);
    #200;
    cs_low = 1'b1;
    #4000;
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the sensor serial slave port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import spi_port_pkg::*;
  logic        MCLK;
  logic        RESET_N;
  logic        sclk;
  logic        mosi;
  logic        cs_low;
  logic        miso_out;
  logic        miso_oe;
  logic        armed;
  wire         miso_line;
  int          n_mismatch;
  int          check_count;
  logic [7:0]  q [7];
  logic [14:0] rows [4];
  assign miso_line = miso_oe ? miso_out : 1'bz;
  sensor_spi_slave_port DUT (.MCLK(MCLK), .RESET_N(RESET_N), .SCLK(sclk), .MOSI(mosi),
    .CHIP_SELECT_LOW(cs_low), .MISO_OUT(miso_out), .MISO_OE(miso_oe), .BURST_ARMED(armed));
  spi_host_model host (.mclk(MCLK), .miso(miso_line), .sclk(sclk), .mosi(mosi),
    .cs_low(cs_low));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    RESET_N = 1'b0;
    repeat (4) @(negedge MCLK);
    RESET_N = 1'b1;
  endtask
  initial
  begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  initial
  begin
    #3000000;
    n_mismatch++;
    complete_run;
  end
  initial
  begin
    n_mismatch = 0;
    check_count = 0;
    // Each row holds a register address above the value written to it.
    rows = '{15'h05a5, 15'h7f5a, 15'h00ff, 15'h4001};
    do_reset;
    chk({7'h00, armed}, 8'h00);
    host.rd(7'h11, 1, 1'b0, q);
    chk(q[0], REG_RESET);
    foreach (rows[i])
    begin
      host.wr(rows[i][14:8], rows[i][7:0]);
      host.rd(rows[i][14:8], 1, 1'b0, q);
      chk(q[0], rows[i][7:0]);
    end
    host.cut({1'b1, 7'h11}, 8, 1'b0);
    host.cut(8'h22, 8, 1'b0);
    host.rd(7'h11, 1, 1'b0, q);
    chk(q[0], 8'h00);
    host.wr(7'h10, 8'h33);
    host.cut({1'b1, 7'h10}, 8, 1'b1);
    host.cut({1'b1, 7'h10}, 5, 1'b1);
    host.wr(7'h20, 8'h77);
    host.rd(7'h10, 1, 1'b0, q);
    chk(q[0], 8'h33);
    host.rd(7'h20, 1, 1'b0, q);
    chk(q[0], 8'h77);
    for (int k = 0; k < BURST_LEN; k++)
      host.wr(MOTION_ADDR + 7'(k), 8'h40 + 8'(k));
    host.wr(PORT_MODE_ADDR, BURST_ENABLE);
    chk({7'h00, armed}, 8'h01);
    host.rd(MOTION_ADDR, BURST_LEN, 1'b1, q);
    for (int k = 0; k < BURST_LEN; k++)
      chk(q[k], 8'h40 + 8'(k));
    chk({7'h00, armed}, 8'h00);
    host.rd(7'h05, 1, 1'b0, q);
    chk(q[0], 8'h43);
    host.wr(PORT_MODE_ADDR, BURST_ENABLE);
    host.rd(MOTION_ADDR, 3, 1'b0, q);
    chk(q[2], 8'h42);
    do_reset;
    chk({7'h00, armed}, 8'h00);
    host.rd(7'h05, 1, 1'b0, q);
    chk(q[0], REG_RESET);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
